// File: common/fdp_pkg.sv
// fdp_pkg: constants, modes and formats of the floating-point dsp datapath.
// assumes one clock domain and a plain register port on the user side.
// How it works
// - multiply mode outputs x times y and raises only the multiplier flags.
// - add mode outputs add operand y plus or minus add operand x with adder flags.
// - multiply-add with cascade input on outputs the product plus or minus cascade in.
// - multiply-add with cascade input off outputs the product plus or minus add operand x.
// - multiply-accumulate with accumulate high combines the product with the last result.
// - with accumulate low the multiply-accumulate mode outputs the bare product.
// - vector one with cascade on outputs product plus or minus cascade in, forwards x.
// - vector one with cascade off outputs the bare product and still forwards x.
// - vector two with cascade on sends the product to cascade out and outputs x plus or minus cascade in.
// - vector two with cascade off outputs add operand x as is, product to cascade out.
// - half sum mode outputs upper product plus or minus lower product in single format.
// - half sum with add combines both products then adds or subtracts add operand x.
// - half sum accumulate with accumulate high adds or subtracts the last result.
// - half sum accumulate with accumulate low outputs just the product sum.
// - flushed and bfloat inputs give four flags each for upper, lower and half adder.
// - extended inputs swap overflow and underflow for infinite and zero flags.
package fdp_pkg;
    localparam int REG_AW = 8;
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_MASK = 8'h04;
    localparam logic [19:0] STATUS_RST = 20'h0_0000;
    localparam logic [19:0] MASK_RST = 20'h0_0000;
    localparam logic [31:0] WORD_RST = 32'h0000_0000;
    localparam int ST_SPMUL = 0;
    localparam int ST_SPADD = 4;
    localparam int ST_HPUP = 8;
    localparam int ST_HPLO = 12;
    localparam int ST_HPADD = 16;
    localparam logic [3:0] FLG_INV_M = 4'h8;
    localparam logic [3:0] FLG_UNF_INX_M = 4'h5;
    localparam logic [3:0] FLG_OVF_INX_M = 4'h6;
    localparam int FLG_ZERO_BIT = 0;
    localparam logic [31:0] SP_QNAN = 32'h7FC0_0000;
    localparam logic [30:0] SP_INF_MAG = 31'h7F80_0000;
    localparam logic [7:0] SP_EXP_ONES = 8'hFF;
    localparam logic [9:0] SP_BIAS = 10'h07F;
    localparam logic [9:0] SP_EXP_MAX = 10'h0FF;
    localparam logic [4:0] HP_EXP_ONES = 5'h1F;
    localparam logic [7:0] HP_REBIAS = 8'h70;
    localparam logic [7:0] ALIGN_MAX = 8'h1A;
    typedef enum logic [3:0] {
        FDP_MUL, FDP_ADD, FDP_MULADD, FDP_MULACC, FDP_VEC1, FDP_VEC2,
        FDP_HSUM, FDP_HSUM_ADD, FDP_HSUM_ACC
    } fdp_mode_e;
    typedef enum logic [1:0] {HP_FLUSHED, HP_BFLOAT, HP_EXTENDED} fdp_hpfmt_e;
endpackage

// File: logic/fdp_datapath.sv
// fdp_datapath: single-precision and half-precision float datapath of one dsp slice.
// assumes operands synchronous to CORE_CLK; one register stage to every output.
`timescale 1ns/1ps
module fdp_datapath (
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic RSTN,
    input wire logic CLK_EN,
    // mode controls
    input wire fdp_pkg::fdp_mode_e MODE,
    input wire fdp_pkg::fdp_hpfmt_e HP_FORMAT,
    input wire logic ACCUMULATE,
    input wire logic CHAIN_EN,
    input wire logic SUB_OUTER,
    input wire logic SUB_INNER,
    // operands
    input wire logic [31:0] SP_MUL_OPND_X,
    input wire logic [31:0] SP_MUL_OPND_Y,
    input wire logic [31:0] SP_ADD_OPND_X,
    input wire logic [31:0] SP_ADD_OPND_Y,
    input wire logic [15:0] HP_UPPER_OPND_X,
    input wire logic [15:0] HP_UPPER_OPND_Y,
    input wire logic [15:0] HP_LOWER_OPND_X,
    input wire logic [15:0] HP_LOWER_OPND_Y,
    input wire logic [31:0] CASCADE_IN_WORD,
    // results and flags
    output logic [31:0] SP_RESULT_OUT,
    output logic [31:0] CASCADE_OUT_WORD,
    output logic [3:0] SP_MUL_FLAGS,
    output logic [3:0] SP_ADD_FLAGS,
    output logic [3:0] HP_UPPER_FLAGS,
    output logic [3:0] HP_LOWER_FLAGS,
    output logic [3:0] HP_ADD_FLAGS,
    // register port
    input wire logic [fdp_pkg::REG_AW-1:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [31:0] REG_RDATA,
    output logic IRQ
);
    import fdp_pkg::*;

    // round to nearest even, then range check; subnormals flush to zero
    function automatic logic [35:0] fpack(input logic s, input logic [9:0] e,
                                          input logic [23:0] m, input logic g,
                                          input logic st);
        logic [24:0] r;
        logic [9:0] ee;
        r = {1'b0, m} + {24'd0, g & (st | m[0])};
        ee = e;
        if (r[24]) begin
            r = r >> 1;
            ee = ee + 10'd1;
        end
        if (ee[9] || ee == 10'd0) begin
            fpack = {FLG_UNF_INX_M, s, 31'd0};
        end else if (ee >= SP_EXP_MAX) begin
            fpack = {FLG_OVF_INX_M, s, SP_INF_MAG};
        end else begin
            fpack = {1'b0, g | st, 2'b00, s, ee[7:0], r[22:0]};
        end
    endfunction

    function automatic logic [35:0] fmul(input logic [31:0] a, input logic [31:0] b);
        logic s;
        logic [47:0] p;
        logic [9:0] e;
        s = a[31] ^ b[31];
        p = {24'd0, 1'b1, a[22:0]} * {24'd0, 1'b1, b[22:0]};
        e = {2'b00, a[30:23]} + {2'b00, b[30:23]} - SP_BIAS + {9'd0, p[47]};
        if (!p[47]) begin
            p = p << 1;
        end
        fmul = {4'h0, s, 31'd0};
        if (a[30:0] > SP_INF_MAG || b[30:0] > SP_INF_MAG ||
            (a[30:0] == SP_INF_MAG && b[30:23] == 8'd0) ||
            (b[30:0] == SP_INF_MAG && a[30:23] == 8'd0)) begin
            fmul = {FLG_INV_M, SP_QNAN};
        end else if (a[30:0] == SP_INF_MAG || b[30:0] == SP_INF_MAG) begin
            fmul = {4'h0, s, SP_INF_MAG};
        end else if (a[30:23] != 8'd0 && b[30:23] != 8'd0) begin
            fmul = fpack(s, e, p[47:24], p[23], |p[22:0]);
        end
    endfunction

    function automatic logic [35:0] fadd(input logic [31:0] a, input logic [31:0] b,
                                         input logic sub);
        logic [31:0] bb;
        logic [31:0] x;
        logic [31:0] y;
        logic [7:0] d;
        logic [53:0] sh;
        logic [27:0] xm;
        logic [27:0] ym;
        logic [27:0] sm;
        logic [9:0] lz;
        bb = {b[31] ^ sub, b[30:0]};
        x = a;
        y = bb;
        if (bb[30:0] > a[30:0]) begin
            x = bb;
            y = a;
        end
        xm = {1'b0, 1'b1, x[22:0], 3'b000};
        ym = {1'b0, 1'b1, y[22:0], 3'b000};
        if (x[30:23] == 8'd0) begin
            xm = 28'd0;
        end
        if (y[30:23] == 8'd0) begin
            ym = 28'd0;
        end
        d = x[30:23] - y[30:23];
        sh = {ym[26:0], 27'd0} >> d;
        if (d > ALIGN_MAX) begin
            ym = {27'd0, ym != 28'd0};
        end else begin
            ym = {1'b0, sh[53:28], sh[27] | (|sh[26:0])};
        end
        sm = (x[31] == y[31]) ? xm + ym : xm - ym;
        lz = 10'd0;
        fadd = {FLG_INV_M, SP_QNAN};
        if (a[30:0] > SP_INF_MAG || b[30:0] > SP_INF_MAG) begin
            fadd = {FLG_INV_M, SP_QNAN};
        end else if (a[30:0] == SP_INF_MAG && bb[30:0] == SP_INF_MAG) begin
            if (a[31] == bb[31]) begin
                fadd = {4'h0, a};
            end
        end else if (a[30:0] == SP_INF_MAG) begin
            fadd = {4'h0, a};
        end else if (bb[30:0] == SP_INF_MAG) begin
            fadd = {4'h0, bb};
        end else if (sm == 28'd0) begin
            fadd = {4'h0, 32'd0};
        end else begin
            for (int i = 0; i < 27; i++) begin
                if (!sm[27]) begin
                    sm = sm << 1;
                    lz = lz + 10'd1;
                end
            end
            fadd = fpack(x[31], {2'b00, x[30:23]} + 10'd1 - lz, sm[27:4], sm[3],
                         |sm[2:0]);
        end
    endfunction

    // half formats widen exactly into the single layout; flushed and extended subnormals become zero
    function automatic logic [31:0] hcvt(input logic [15:0] h, input fdp_hpfmt_e f);
        hcvt = {h[15], 31'd0};
        if (f == HP_BFLOAT) begin
            hcvt = {h, 16'h0000};
        end else if (h[14:10] == HP_EXP_ONES && f != HP_EXTENDED) begin
            hcvt = {h[15], SP_EXP_ONES, h[9:0], 13'h0000};
        end else if (h[14:10] != 5'h00) begin
            hcvt = {h[15], {3'b000, h[14:10]} + HP_REBIAS, h[9:0], 13'h0000};
        end
    endfunction

    function automatic logic [3:0] hflag(input logic [35:0] r, input logic ext);
        hflag = r[35:32];
        if (ext) begin
            hflag = {r[35:34], r[30:0] == SP_INF_MAG, r[30:0] == 31'd0};
        end
    endfunction

    logic [31:0] mul_q;
    logic [3:0] mul_f;
    logic [31:0] top_q;
    logic [3:0] top_f;
    logic [31:0] bot_q;
    logic [3:0] bot_f;
    logic [31:0] hs_q;
    logic [3:0] hs_f;
    logic [31:0] add_q;
    logic [3:0] add_f;
    logic [31:0] add_a;
    logic [31:0] add_b;
    logic [31:0] base_res;
    logic [31:0] nxt_res;
    logic [31:0] nxt_cout;
    logic use_mul;
    logic use_add;
    logic use_hp;
    logic hp_ext;
    logic [19:0] events;
    logic [19:0] nxt_status;
    logic [31:0] res_ff;
    logic [31:0] cout_ff;
    logic [19:0] flags_ff;
    logic [19:0] status_ff;
    logic [19:0] mask_ff;
    logic [31:0] rdata_ff;
    logic irq_ff;

    assign hp_ext = (HP_FORMAT == HP_EXTENDED);
    assign {mul_f, mul_q} = fmul(SP_MUL_OPND_X, SP_MUL_OPND_Y);
    assign {top_f, top_q} = fmul(hcvt(HP_UPPER_OPND_X, HP_FORMAT),
                                 hcvt(HP_UPPER_OPND_Y, HP_FORMAT));
    assign {bot_f, bot_q} = fmul(hcvt(HP_LOWER_OPND_X, HP_FORMAT),
                                 hcvt(HP_LOWER_OPND_Y, HP_FORMAT));
    assign {hs_f, hs_q} = fadd(top_q, bot_q, SUB_INNER);
    // one shared adder; the mode only picks its two inputs
    assign {add_f, add_q} = fadd(add_a, add_b, SUB_OUTER);

    always_comb begin
        add_a = mul_q;
        add_b = SP_ADD_OPND_X;
        base_res = mul_q;
        nxt_cout = WORD_RST;
        use_mul = 1'b0;
        use_add = 1'b0;
        use_hp = 1'b0;
        case (MODE)
            FDP_MUL: begin
                use_mul = 1'b1;
            end
            FDP_ADD: begin
                add_a = SP_ADD_OPND_Y;
                use_add = 1'b1;
            end
            FDP_MULADD: begin
                use_mul = 1'b1;
                use_add = 1'b1;
                add_b = CHAIN_EN ? CASCADE_IN_WORD : SP_ADD_OPND_X;
            end
            FDP_MULACC: begin
                use_mul = 1'b1;
                use_add = ACCUMULATE;
                add_b = res_ff;
            end
            FDP_VEC1: begin
                use_mul = 1'b1;
                use_add = CHAIN_EN;
                add_b = CASCADE_IN_WORD;
                nxt_cout = SP_ADD_OPND_X;
            end
            FDP_VEC2: begin
                use_mul = 1'b1;
                use_add = CHAIN_EN;
                add_a = SP_ADD_OPND_X;
                add_b = CASCADE_IN_WORD;
                base_res = SP_ADD_OPND_X;
                nxt_cout = mul_q;
            end
            FDP_HSUM: begin
                use_hp = 1'b1;
                base_res = hs_q;
            end
            FDP_HSUM_ADD: begin
                use_hp = 1'b1;
                use_add = 1'b1;
                add_a = hs_q;
            end
            FDP_HSUM_ACC: begin
                use_hp = 1'b1;
                use_add = ACCUMULATE;
                add_a = hs_q;
                add_b = res_ff;
                base_res = hs_q;
            end
            default: begin
                use_mul = 1'b0;
            end
        endcase
    end

    assign nxt_res = use_add ? add_q : base_res;
    // flags of units that the mode does not use stay quiet
    assign events[ST_SPMUL+:4] = use_mul ? mul_f : 4'h0;
    assign events[ST_SPADD+:4] = use_add ? add_f : 4'h0;
    assign events[ST_HPUP+:4] = use_hp ? hflag({top_f, top_q}, hp_ext) : 4'h0;
    assign events[ST_HPLO+:4] = use_hp ? hflag({bot_f, bot_q}, hp_ext) : 4'h0;
    assign events[ST_HPADD+:4] = use_hp ? hflag({hs_f, hs_q}, hp_ext) : 4'h0;
    // set wins over the read clear
    assign nxt_status = ((REG_RD && REG_ADDR == REG_STATUS) ? STATUS_RST : status_ff) | events;

    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            res_ff <= WORD_RST;
            cout_ff <= WORD_RST;
            flags_ff <= STATUS_RST;
        end else if (CLK_EN) begin
            res_ff <= nxt_res;
            cout_ff <= nxt_cout;
            flags_ff <= events;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            status_ff <= STATUS_RST;
            mask_ff <= MASK_RST;
            irq_ff <= 1'b0;
        end else if (CLK_EN) begin
            status_ff <= nxt_status;
            if (REG_WR && REG_ADDR == REG_MASK) begin
                mask_ff <= REG_WDATA[19:0];
            end
            irq_ff <= |(nxt_status & mask_ff);
        end
    end

    // read data stand for one cycle only; unmapped reads give zero
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            rdata_ff <= WORD_RST;
        end else if (CLK_EN) begin
            rdata_ff <= WORD_RST;
            if (REG_RD && REG_ADDR == REG_STATUS) begin
                rdata_ff <= {12'h000, status_ff};
            end else if (REG_RD && REG_ADDR == REG_MASK) begin
                rdata_ff <= {12'h000, mask_ff};
            end
        end
    end

    assign SP_RESULT_OUT = res_ff;
    assign CASCADE_OUT_WORD = cout_ff;
    assign SP_MUL_FLAGS = flags_ff[ST_SPMUL+:4];
    assign SP_ADD_FLAGS = flags_ff[ST_SPADD+:4];
    assign HP_UPPER_FLAGS = flags_ff[ST_HPUP+:4];
    assign HP_LOWER_FLAGS = flags_ff[ST_HPLO+:4];
    assign HP_ADD_FLAGS = flags_ff[ST_HPADD+:4];
    assign REG_RDATA = rdata_ff;
    assign IRQ = irq_ff;

    default clocking dc @(posedge CORE_CLK); endclocking
    default disable iff (!RSTN);

    a_mul_product: assert property (CLK_EN && MODE == FDP_MUL |=>
        SP_RESULT_OUT == $past(mul_q) && SP_ADD_FLAGS == 4'h0)
        else $error("multiply mode result wrong");
    a_add_operands: assert property (CLK_EN && MODE == FDP_ADD |->
        add_a == SP_ADD_OPND_Y && add_b == SP_ADD_OPND_X ##1 SP_MUL_FLAGS == 4'h0)
        else $error("add mode operands wrong");
    a_chain_addend: assert property (MODE == FDP_MULADD && CHAIN_EN |->
        add_a == mul_q && add_b == CASCADE_IN_WORD)
        else $error("cascade addend not used");
    a_local_addend: assert property (MODE == FDP_MULADD && !CHAIN_EN |->
        add_b == SP_ADD_OPND_X)
        else $error("local addend not used");
    a_acc_feedback: assert property (CLK_EN && MODE == FDP_MULACC && ACCUMULATE |->
        add_b == SP_RESULT_OUT ##1 SP_RESULT_OUT == $past(add_q))
        else $error("accumulate feedback wrong");
    a_acc_cleared: assert property (CLK_EN && MODE == FDP_MULACC && !ACCUMULATE |=>
        SP_RESULT_OUT == $past(mul_q))
        else $error("accumulate low not bare product");
    a_vec1_forward: assert property (CLK_EN && MODE == FDP_VEC1 |=>
        CASCADE_OUT_WORD == $past(SP_ADD_OPND_X))
        else $error("vector one cascade out wrong");
    a_vec2_route: assert property (CLK_EN && MODE == FDP_VEC2 |=>
        CASCADE_OUT_WORD == $past(mul_q))
        else $error("vector two cascade out wrong");
    a_vec2_bypass: assert property (CLK_EN && MODE == FDP_VEC2 && !CHAIN_EN |=>
        SP_RESULT_OUT == $past(SP_ADD_OPND_X))
        else $error("vector two bypass wrong");
    a_hsum_result: assert property (CLK_EN && MODE == FDP_HSUM |=>
        SP_RESULT_OUT == $past(hs_q))
        else $error("half sum result wrong");
    a_hsum_addend: assert property (MODE == FDP_HSUM_ADD |->
        use_add && add_a == hs_q && add_b == SP_ADD_OPND_X)
        else $error("half sum addend wrong");
    a_hacc_select: assert property (CLK_EN && MODE == FDP_HSUM_ACC |=>
        SP_RESULT_OUT == ($past(ACCUMULATE) ? $past(add_q) : $past(hs_q)))
        else $error("half accumulate result wrong");
    a_hp_quiet: assert property (CLK_EN && !use_hp |=>
        HP_UPPER_FLAGS == 4'h0 && HP_LOWER_FLAGS == 4'h0 && HP_ADD_FLAGS == 4'h0)
        else $error("half flags raised outside half modes");
    a_ext_zero: assert property (CLK_EN && use_hp && hp_ext && bot_q[30:0] == 31'd0 |=>
        HP_LOWER_FLAGS[FLG_ZERO_BIT])
        else $error("extended zero flag missing");

    c_mul_acc: cover property (CLK_EN && MODE == FDP_MULACC && ACCUMULATE ##1
        CLK_EN && MODE == FDP_MULACC && ACCUMULATE);
    c_vec2_chain: cover property (CLK_EN && MODE == FDP_VEC2 && CHAIN_EN);
    c_hsum_add: cover property (CLK_EN && MODE == FDP_HSUM_ADD && SUB_INNER && SUB_OUTER);
    c_irq_rise: cover property (!IRQ ##1 IRQ);
endmodule // fdp_datapath

// File: verification/fdp_datapath_tb.sv
// fdp_datapath_tb: self-checking bench for the float dsp datapath.
// assumes one register stage to every output and a single 100 MHz clock.
`timescale 1ns/1ps
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin n_fail++; \
    $display("[ERR] %0t mismatch got %h exp %h", $time, (got), (exp)); end end
module fdp_datapath_tb;
    import fdp_pkg::*;
    localparam logic [31:0] F0 = 32'h0000_0000;
    localparam logic [31:0] F1 = 32'h3F80_0000;
    localparam logic [31:0] F2 = 32'h4000_0000;
    localparam logic [31:0] F3 = 32'h4040_0000;
    localparam logic [31:0] F4 = 32'h4080_0000;
    localparam logic [31:0] F5 = 32'h40A0_0000;
    localparam logic [31:0] F6 = 32'h40C0_0000;
    localparam logic [31:0] F7 = 32'h40E0_0000;
    localparam logic [31:0] F8 = 32'h4100_0000;
    localparam logic [31:0] F12 = 32'h4140_0000;
    localparam logic [31:0] F14 = 32'h4160_0000;
    localparam logic [31:0] M12 = 32'hC140_0000;
    localparam logic [31:0] M14 = 32'hC160_0000;
    localparam logic [31:0] F64K = 32'h4780_0000;
    localparam logic [31:0] BIG = 32'h7F00_0000;
    localparam logic [31:0] INF = 32'h7F80_0000;
    localparam logic [31:0] VX = 32'h4049_0FDB;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic clk_en = 1'b1;
    fdp_mode_e mode = FDP_MUL;
    fdp_hpfmt_e hp_format = HP_FLUSHED;
    fdp_hpfmt_e c_fmt = HP_FLUSHED;
    logic accumulate = 1'b0;
    logic chain_en = 1'b0;
    logic sub_outer = 1'b0;
    logic sub_inner = 1'b0;
    logic [31:0] mul_x = F0, mul_y = F0, add_x = F0, add_y = F0, up_word = F0;
    logic [31:0] c_mx = F2, c_my = F3;
    logic [15:0] hp_ux = 16'h0000, hp_uy = 16'h0000, hp_lx = 16'h0000, hp_ly = 16'h0000;
    logic [15:0] c_ux = 16'h4000, c_uy = 16'h4200, c_lx = 16'h3C00, c_ly = 16'h3C00;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = F0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] result, cas_out, cas_in, reg_rdata, seen_word;
    logic [3:0] mul_flg, add_flg, hup_flg, hlo_flg, hadd_flg;
    logic irq;
    int n_fail = 0;
    int num_checks = 0;

    always #5 core_clk = ~core_clk;

    fdp_datapath u_dut (
        .CORE_CLK(core_clk), .RSTN(rstn), .CLK_EN(clk_en), .MODE(mode), .HP_FORMAT(hp_format),
        .ACCUMULATE(accumulate), .CHAIN_EN(chain_en), .SUB_OUTER(sub_outer),
        .SUB_INNER(sub_inner), .SP_MUL_OPND_X(mul_x), .SP_MUL_OPND_Y(mul_y),
        .SP_ADD_OPND_X(add_x), .SP_ADD_OPND_Y(add_y), .HP_UPPER_OPND_X(hp_ux),
        .HP_UPPER_OPND_Y(hp_uy), .HP_LOWER_OPND_X(hp_lx), .HP_LOWER_OPND_Y(hp_ly),
        .CASCADE_IN_WORD(cas_in), .SP_RESULT_OUT(result), .CASCADE_OUT_WORD(cas_out),
        .SP_MUL_FLAGS(mul_flg), .SP_ADD_FLAGS(add_flg), .HP_UPPER_FLAGS(hup_flg),
        .HP_LOWER_FLAGS(hlo_flg), .HP_ADD_FLAGS(hadd_flg), .REG_ADDR(reg_addr),
        .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
        .IRQ(irq)
    );

    fdp_neighbour_slice u_nbr (.clk(core_clk), .rstn(rstn), .up_word(up_word),
        .cascade_in_word(cas_in), .cascade_out_word(cas_out), .seen_word_ff(seen_word));

    task automatic test_done;
        $display("checks %0d errors %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ctl: chain, accumulate, subtract outer, subtract inner; result one edge after driving
    task automatic op(input fdp_mode_e m, input logic [3:0] ctl, input logic [31:0] ax, ay,
                      input logic [31:0] cin, er, ec);
        @(posedge core_clk);
        mode <= m;
        hp_format <= c_fmt;
        chain_en <= ctl[3];
        accumulate <= ctl[2];
        sub_outer <= ctl[1];
        sub_inner <= ctl[0];
        mul_x <= c_mx;
        mul_y <= c_my;
        add_x <= ax;
        add_y <= ay;
        hp_ux <= c_ux;
        hp_uy <= c_uy;
        hp_lx <= c_lx;
        hp_ly <= c_ly;
        up_word <= cin;
        @(posedge core_clk);
        #1;
        `CHK(result, er)
        `CHK(cas_out, ec)
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task automatic t_irq;
        logic [31:0] d;
        int k;
        reg_read(REG_STATUS, d);
        `CHK(d, {12'h000, STATUS_RST})
        reg_read(REG_MASK, d);
        `CHK(d, {12'h000, MASK_RST})
        reg_write(REG_MASK, 32'hFFFF_FFFF);
        reg_read(REG_MASK, d);
        `CHK(d, 32'h000F_FFFF)
        reg_write(8'h08, 32'h0000_0000);
        reg_read(8'h08, d);
        `CHK(d, 32'h0000_0000)
        // overflow while masked: status records it, no interrupt
        reg_write(REG_MASK, 32'h0000_0010);
        c_mx = BIG;
        c_my = BIG;
        op(FDP_MUL, 4'h0, F0, F0, F0, INF, F0);
        c_mx = F2;
        c_my = F3;
        op(FDP_MUL, 4'h0, F0, F0, F0, F6, F0);
        `CHK(irq, 1'b0)
        reg_read(REG_STATUS, d);
        `CHK(d, 32'h0000_0006)
        reg_write(REG_MASK, 32'h0000_0002);
        c_mx = BIG;
        c_my = BIG;
        op(FDP_MUL, 4'h0, F0, F0, F0, INF, F0);
        for (k = 0; k < 4 && irq !== 1'b1; k++) begin
            @(posedge core_clk);
            #1;
        end
        `CHK(irq, 1'b1)
        c_mx = F2;
        c_my = F3;
        op(FDP_MUL, 4'h0, F0, F0, F0, F6, F0);
        reg_read(REG_STATUS, d);
        `CHK(d, 32'h0000_0006)
        // the read edge clears status and drops the interrupt together
        `CHK(irq, 1'b0)
    endtask

    task automatic t_sp;
        op(FDP_MUL, 4'h0, F1, F1, F1, F6, F0);
        op(FDP_ADD, 4'h0, F1, F3, F0, F4, F0);
        op(FDP_ADD, 4'h2, F1, F3, F0, F2, F0);
        op(FDP_MULADD, 4'h8, F5, F0, F1, F7, F0);
        op(FDP_MULADD, 4'hA, F5, F0, F1, F5, F0);
        op(FDP_MULADD, 4'h2, F1, F0, F5, F5, F0);
        op(FDP_MULADD, 4'h0, F1, F0, F5, F7, F0);
    endtask

    // a frozen slice keeps its last result whatever its inputs do
    task automatic t_hold;
        @(posedge core_clk);
        clk_en <= 1'b0;
        op(FDP_ADD, 4'h0, F1, F3, F0, F7, F0);
        @(posedge core_clk);
        clk_en <= 1'b1;
    endtask

    // each op is sampled twice, so the held accumulate step doubles up once
    task automatic t_acc;
        op(FDP_MULACC, 4'h0, F1, F0, F1, F6, F0);
        op(FDP_MULACC, 4'h4, F1, F0, F1, F12, F0);
        op(FDP_MULACC, 4'h6, F1, F0, F1, M12, F0);
        op(FDP_MULACC, 4'h2, F1, F0, F1, F6, F0);
    endtask

    task automatic t_vec;
        op(FDP_VEC1, 4'h8, VX, F0, F1, F7, VX);
        op(FDP_VEC1, 4'hA, VX, F0, F1, F5, VX);
        op(FDP_VEC1, 4'h0, VX, F0, F1, F6, VX);
        op(FDP_VEC2, 4'h8, F5, F0, F1, F6, F6);
        op(FDP_VEC2, 4'hA, F5, F0, F1, F4, F6);
        op(FDP_VEC2, 4'h0, F5, F0, F1, F5, F6);
        @(posedge core_clk);
        #1;
        `CHK(seen_word, F6)
    endtask

    task automatic t_half;
        logic [31:0] exp_add [4];
        exp_add = '{F8, F6, F6, F4};
        op(FDP_HSUM, 4'h0, F1, F0, F1, F7, F0);
        op(FDP_HSUM, 4'h1, F1, F0, F1, F5, F0);
        for (int i = 0; i < 4; i++) begin
            op(FDP_HSUM_ADD, i[3:0], F1, F0, F0, exp_add[i], F0);
        end
        op(FDP_HSUM_ACC, 4'h0, F1, F0, F1, F7, F0);
        op(FDP_HSUM_ACC, 4'h4, F1, F0, F1, F14, F0);
        op(FDP_HSUM_ACC, 4'h6, F1, F0, F1, M14, F0);
        op(FDP_HSUM_ACC, 4'h2, F1, F0, F1, F7, F0);
        // same plain half sum in the bfloat layout
        c_fmt = HP_BFLOAT;
        c_uy = 16'h4040;
        c_lx = 16'h3F80;
        c_ly = 16'h3F80;
        op(FDP_HSUM, 4'h0, F1, F0, F1, F7, F0);
    endtask

    task automatic t_flags;
        c_mx = BIG;
        c_my = BIG;
        op(FDP_MUL, 4'h0, F0, F0, F0, INF, F0);
        `CHK(mul_flg, FLG_OVF_INX_M)
        `CHK(add_flg, 4'h0)
        op(FDP_ADD, 4'h2, INF, INF, F0, SP_QNAN, F0);
        `CHK(add_flg, FLG_INV_M)
        `CHK(mul_flg, 4'h0)
        // infinity times zero in the flushed layout
        c_fmt = HP_FLUSHED;
        c_ux = 16'h7C00;
        c_uy = 16'h0000;
        c_lx = 16'h3C00;
        c_ly = 16'h3C00;
        op(FDP_HSUM, 4'h0, F0, F0, F0, SP_QNAN, F0);
        `CHK(hup_flg, FLG_INV_M)
        `CHK(hlo_flg, 4'h0)
        `CHK(hadd_flg, FLG_INV_M)
        // top exponent is finite in the extended layout; zero product raises the zero flag
        c_fmt = HP_EXTENDED;
        c_uy = 16'h3C00;
        c_lx = 16'h0000;
        op(FDP_HSUM, 4'h0, F0, F0, F0, F64K, F0);
        `CHK(hup_flg, 4'h0)
        `CHK(hlo_flg, 4'h1)
        `CHK(hadd_flg, 4'h0)
    endtask

    initial begin
        repeat (8) @(posedge core_clk);
        rstn <= 1'b1;
        t_irq;
        t_sp;
        t_hold;
        t_acc;
        t_vec;
        t_half;
        t_flags;
        test_done;
    end

    // hang guard well above the run time of the test
    initial begin
        #1_000_000;
        $display("[ERR] %0t timeout", $time);
        n_fail++;
        test_done;
    end
endmodule // fdp_datapath_tb

// File: verification/fdp_neighbour_slice.sv
// fdp_neighbour_slice: stand-in for the slices above and below on the cascade.
// assumes the bench sets the upstream word by non-blocking assignment after an edge.
`timescale 1ns/1ps
module fdp_neighbour_slice (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // upstream slice
    input wire logic [31:0] up_word,
    output logic [31:0] cascade_in_word,
    // downstream slice
    input wire logic [31:0] cascade_out_word,
    output logic [31:0] seen_word_ff
);
    // upstream output register folded into the bench timing, so no extra lag here
    assign cascade_in_word = up_word;

    // downstream input register takes the chain word at every edge
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            seen_word_ff <= 32'h0000_0000;
        end else begin
            seen_word_ff <= cascade_out_word;
        end
    end
endmodule // fdp_neighbour_slice
